// ### src/cssx_exec.sv
// Compact store and subtract-immediate execution unit with AHB-Lite registers
module cssx_exec
  import cssx_pkg::*;
(
  input  wire logic        CORE_CLK_I,
  input  wire logic        RST_B_I,
  input  wire logic        HSEL_I,
  input  wire logic [31:0] HADDR_I,
  input  wire logic [1:0]  HTRANS_I,
  input  wire logic        HWRITE_I,
  input  wire logic [2:0]  HSIZE_I,
  input  wire logic [31:0] HWDATA_I,
  input  wire logic        HREADY_I,
  output logic      [31:0] HRDATA_O,
  output logic             HREADYOUT_O,
  output logic             HRESP_O,
  output logic             DMEM_REQ_O,
  output logic      [31:0] DMEM_ADDR_O,
  output logic      [31:0] DMEM_WDATA_O,
  output logic      [3:0]  DMEM_BE_O,
  input  wire logic        DMEM_DONE_I,
  input  wire logic        DMEM_ABORT_I,
  output logic             EXC_ALIGN_O,
  output logic             EXC_ABORT_O
);

  logic           rst_meta;
  logic           rst_n;
  logic           wr_pend;
  logic           rd_pend;
  logic [7:0]     ph_addr;
  logic           ctrl_align;
  logic [31:0]    base_q;
  logic [31:0]    offset_q;
  logic [31:0]    src_q;
  logic [7:0]     imm_q;
  logic [31:0]    result_q;
  logic [31:0]    laddr_q;
  logic [3:0]     flags_q;
  logic           done_q;
  logic           align_q;
  logic           abort_q;
  cssx_state_type state;

  // Reset release through two flip-flops
  always_ff @(posedge CORE_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  // Bus address phase decode
  wire acc    = HSEL_I & HTRANS_I[1] & HREADY_I;
  wire wr_ctl = wr_pend && (ph_addr == ADDR_CTRL);
  wire wr_bas = wr_pend && (ph_addr == ADDR_BASE);
  wire wr_off = wr_pend && (ph_addr == ADDR_OFFSET);
  wire wr_src = wr_pend && (ph_addr == ADDR_SRC);
  wire wr_imm = wr_pend && (ph_addr == ADDR_IMM);
  wire wr_cmd = wr_pend && (ph_addr == ADDR_CMD);
  wire wr_sts = wr_pend && (ph_addr == ADDR_STATUS);

  // Command decode straight from the write data
  wire         op_ok  = HWDATA_I[2:0] < OP_COUNT;
  cssx_op_type cmd_op;
  assign cmd_op = cssx_op_type'(HWDATA_I[2:0]);
  wire launch  = wr_cmd && op_ok && (state == EX_IDLE);
  wire is_half = (cmd_op == OP_ST_HALF_IMM) || (cmd_op == OP_ST_HALF_REG);
  wire is_sub  = (cmd_op == OP_SUB_IMM3) || (cmd_op == OP_SUB_IMM8);

  // Store address forming
  wire [31:0] off_imm_b = {27'h0, imm_q[4:0]};
  wire [31:0] off_imm_h = {26'h0, imm_q[4:0], 1'b0};
  wire [31:0] st_off    = (cmd_op == OP_ST_BYTE_IMM) ? off_imm_b :
                          (cmd_op == OP_ST_HALF_IMM) ? off_imm_h :
                          offset_q;
  wire [31:0] st_addr   = base_q + st_off;
  wire        misalign  = is_half && st_addr[0] && ctrl_align;
  wire        st_go     = launch && !is_sub && !misalign;

  // Store lanes; a misaligned halfword simply uses its pair of lanes
  wire [7:0]  src_b   = src_q[7:0];
  wire [15:0] src_h   = src_q[15:0];
  wire [3:0]  be_byte = 4'h1 << st_addr[1:0];
  wire [3:0]  be_half = st_addr[1] ? 4'hc : 4'h3;
  wire [31:0] st_data = is_half ? {2{src_h}} : {4{src_b}};

  // Subtract datapath with zero-extended immediates
  wire [31:0] imm3w    = {29'h0, imm_q[2:0]};
  wire [31:0] imm8w    = {24'h0, imm_q};
  wire        sub3     = cmd_op == OP_SUB_IMM3;
  wire [31:0] sub_a    = sub3 ? base_q : src_q;
  wire [31:0] sub_b    = sub3 ? imm3w : imm8w;
  wire [32:0] sub_full = {1'b0, sub_a} - {1'b0, sub_b};
  wire [31:0] sub_res  = sub_full[31:0];
  wire        sub_n    = sub_res[31];
  wire        sub_z    = sub_res == 32'h0;
  wire        sub_c    = ~sub_full[32];
  wire        sub_v    = (sub_a[31] ^ sub_b[31]) & (sub_a[31] ^ sub_res[31]);

  // Sticky status with set winning over a write-one clear
  wire mem_end    = (state == EX_MEM) && (DMEM_DONE_I || DMEM_ABORT_I);
  wire set_done   = (launch && is_sub) || ((state == EX_MEM) && DMEM_DONE_I && !DMEM_ABORT_I);
  wire set_align  = launch && !is_sub && misalign;
  wire set_abort  = (state == EX_MEM) && DMEM_ABORT_I;
  wire next_done  = (done_q & ~(wr_sts & HWDATA_I[STAT_DONE])) | set_done;
  wire next_align = (align_q & ~(wr_sts & HWDATA_I[STAT_ALIGN])) | set_align;
  wire next_abort = (abort_q & ~(wr_sts & HWDATA_I[STAT_ABORT])) | set_abort;

  // Read data selection
  wire [31:0] stat_word = {24'h0, flags_q, abort_q, align_q, done_q, state == EX_MEM};
  wire [31:0] rd_mux = (ph_addr == ADDR_CTRL)   ? {31'h0, ctrl_align} :
                       (ph_addr == ADDR_BASE)   ? base_q :
                       (ph_addr == ADDR_OFFSET) ? offset_q :
                       (ph_addr == ADDR_SRC)    ? src_q :
                       (ph_addr == ADDR_IMM)    ? {24'h0, imm_q} :
                       (ph_addr == ADDR_STATUS) ? stat_word :
                       (ph_addr == ADDR_RESULT) ? result_q :
                       (ph_addr == ADDR_LADDR)  ? laddr_q :
                       32'h0;

  // Bus phases; reads take one wait state so they see the latest write
  always_ff @(posedge CORE_CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      wr_pend     <= 1'b0;
      rd_pend     <= 1'b0;
      ph_addr     <= 8'h0;
      HREADYOUT_O <= 1'b1;
      HRESP_O     <= 1'b0;
      HRDATA_O    <= RST_WORD;
    end else begin
      wr_pend     <= acc & HWRITE_I;
      rd_pend     <= acc & ~HWRITE_I;
      HREADYOUT_O <= ~(acc & ~HWRITE_I);
      HRESP_O     <= 1'b0;
      if (acc) begin
        ph_addr <= HADDR_I[7:0];
      end
      if (rd_pend) begin
        HRDATA_O <= rd_mux;
      end
    end
  end

  // Software registers
  always_ff @(posedge CORE_CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_align <= 1'b0;
      base_q     <= RST_WORD;
      offset_q   <= RST_WORD;
      imm_q      <= RST_IMM;
    end else begin
      if (wr_ctl) ctrl_align <= HWDATA_I[CTRL_ALIGN];
      if (wr_bas) base_q <= HWDATA_I;
      if (wr_off) offset_q <= HWDATA_I;
      if (wr_imm) imm_q <= HWDATA_I[7:0];
    end
  end

  // Results, flags and sticky status
  always_ff @(posedge CORE_CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      src_q    <= RST_WORD;
      result_q <= RST_WORD;
      laddr_q  <= RST_WORD;
      flags_q  <= RST_FLAGS;
      done_q   <= 1'b0;
      align_q  <= 1'b0;
      abort_q  <= 1'b0;
    end else begin
      done_q  <= next_done;
      align_q <= next_align;
      abort_q <= next_abort;
      if (launch && is_sub) begin
        result_q <= sub_res;
        flags_q  <= {sub_n, sub_z, sub_c, sub_v};
      end
      if (launch && cmd_op == OP_SUB_IMM8) begin
        src_q <= sub_res;
      end else if (wr_src) begin
        src_q <= HWDATA_I;
      end
      if (launch && !is_sub) begin
        laddr_q <= st_addr;
      end
    end
  end

  // Store sequencer towards data memory
  always_ff @(posedge CORE_CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      state        <= EX_IDLE;
      DMEM_REQ_O   <= 1'b0;
      DMEM_ADDR_O  <= RST_WORD;
      DMEM_WDATA_O <= RST_WORD;
      DMEM_BE_O    <= 4'h0;
      EXC_ALIGN_O  <= 1'b0;
      EXC_ABORT_O  <= 1'b0;
    end else begin
      EXC_ALIGN_O <= set_align;
      EXC_ABORT_O <= set_abort;
      unique case (state)
        EX_IDLE: begin
          if (st_go) begin
            DMEM_REQ_O   <= 1'b1;
            DMEM_ADDR_O  <= st_addr;
            DMEM_WDATA_O <= st_data;
            DMEM_BE_O    <= is_half ? be_half : be_byte;
            state        <= EX_MEM;
          end
        end
        EX_MEM: begin
          if (mem_end) begin
            DMEM_REQ_O <= 1'b0;
            state      <= EX_IDLE;
          end
        end
      endcase
    end
  end

  // Checks on the datapath and sequencer
  default clocking cb @(posedge CORE_CLK_I); endclocking
  default disable iff (!rst_n);

  wire base_sign = base_q[31];
  wire src_sign  = src_q[31];

  property p_byte_imm_addr;
    launch && cmd_op == OP_ST_BYTE_IMM |=>
      DMEM_REQ_O && DMEM_ADDR_O == $past(base_q) + $past(off_imm_b);
  endproperty
  a_byte_imm_addr: assert property (p_byte_imm_addr)
    else $error("byte immediate store address wrong");

  property p_byte_reg_addr;
    launch && cmd_op == OP_ST_BYTE_REG |=> DMEM_ADDR_O == $past(base_q) + $past(offset_q);
  endproperty
  a_byte_reg_addr: assert property (p_byte_reg_addr)
    else $error("byte register store address wrong");

  property p_byte_data;
    launch && !is_half && !is_sub |=>
      DMEM_WDATA_O == {4{$past(src_b)}} && $onehot(DMEM_BE_O) && DMEM_BE_O[DMEM_ADDR_O[1:0]];
  endproperty
  a_byte_data: assert property (p_byte_data)
    else $error("byte store lanes or data wrong");

  property p_half_imm_addr;
    launch && cmd_op == OP_ST_HALF_IMM && !misalign |=>
      DMEM_ADDR_O == $past(base_q) + $past(off_imm_h);
  endproperty
  a_half_imm_addr: assert property (p_half_imm_addr)
    else $error("halfword immediate store address wrong");

  property p_half_reg_addr;
    launch && cmd_op == OP_ST_HALF_REG && !misalign |=>
      DMEM_ADDR_O == $past(base_q) + $past(offset_q);
  endproperty
  a_half_reg_addr: assert property (p_half_reg_addr)
    else $error("halfword register store address wrong");

  property p_half_data;
    launch && is_half && !misalign |=>
      DMEM_WDATA_O == {2{$past(src_h)}} && $countones(DMEM_BE_O) == 2;
  endproperty
  a_half_data: assert property (p_half_data)
    else $error("halfword store lanes or data wrong");

  property p_align_fault;
    launch && is_half && ctrl_align && st_addr[0] |=> EXC_ALIGN_O && !DMEM_REQ_O && align_q;
  endproperty
  a_align_fault: assert property (p_align_fault)
    else $error("misaligned halfword did not fault");

  property p_sub3;
    launch && cmd_op == OP_SUB_IMM3 |=> result_q == $past(base_q) - $past(imm3w);
  endproperty
  a_sub3: assert property (p_sub3)
    else $error("short subtract result wrong");

  property p_sub8;
    launch && cmd_op == OP_SUB_IMM8 |=>
      result_q == $past(src_q) - $past(imm8w) && src_q == result_q;
  endproperty
  a_sub8: assert property (p_sub8)
    else $error("long subtract result wrong");

  property p_nz;
    launch && is_sub |=> flags_q[FLAG_N] == result_q[31] && flags_q[FLAG_Z] == (result_q == 0);
  endproperty
  a_nz: assert property (p_nz)
    else $error("negative or zero flag wrong");

  property p_carry;
    launch && cmd_op == OP_SUB_IMM3 |=> flags_q[FLAG_C] == ($past(base_q) >= $past(imm3w));
  endproperty
  a_carry: assert property (p_carry)
    else $error("carry flag wrong");

  property p_v3;
    launch && cmd_op == OP_SUB_IMM3 |=> flags_q[FLAG_V] == ($past(base_sign) && !result_q[31]);
  endproperty
  a_v3: assert property (p_v3)
    else $error("short subtract overflow wrong");

  property p_v8;
    launch && cmd_op == OP_SUB_IMM8 |=> flags_q[FLAG_V] == ($past(src_sign) && !result_q[31]);
  endproperty
  a_v8: assert property (p_v8)
    else $error("long subtract overflow wrong");

  property p_abort;
    DMEM_REQ_O && DMEM_ABORT_I |=> !DMEM_REQ_O && EXC_ABORT_O && abort_q && !$rose(done_q);
  endproperty
  a_abort: assert property (p_abort)
    else $error("abort did not suppress the store");

  property p_sub_no_mem;
    launch && is_sub |=> !DMEM_REQ_O [*2];
  endproperty
  a_sub_no_mem: assert property (p_sub_no_mem)
    else $error("subtract touched memory");

  property p_carry8;
    launch && cmd_op == OP_SUB_IMM8 |=> flags_q[FLAG_C] == ($past(src_q) >= $past(imm8w));
  endproperty
  a_carry8: assert property (p_carry8)
    else $error("long subtract carry wrong");

  // The store payload stands until memory answers
  property p_store_hold;
    DMEM_REQ_O && !DMEM_DONE_I && !DMEM_ABORT_I |=>
      DMEM_REQ_O && $stable(DMEM_ADDR_O) && $stable(DMEM_WDATA_O) && $stable(DMEM_BE_O);
  endproperty
  a_store_hold: assert property (p_store_hold)
    else $error("store request dropped or changed early");

  property p_store_done;
    DMEM_REQ_O && DMEM_DONE_I && !DMEM_ABORT_I |=> !DMEM_REQ_O && done_q && !EXC_ABORT_O;
  endproperty
  a_store_done: assert property (p_store_done)
    else $error("completed store not retired");

endmodule : cssx_exec

// ### src/cssx_pkg.sv
// Register map, opcodes and field positions of the compact store/subtract unit
package cssx_pkg;
  // Register byte offsets
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_BASE   = 8'h04;
  localparam logic [7:0] ADDR_OFFSET = 8'h08;
  localparam logic [7:0] ADDR_SRC    = 8'h0c;
  localparam logic [7:0] ADDR_IMM    = 8'h10;
  localparam logic [7:0] ADDR_CMD    = 8'h14;
  localparam logic [7:0] ADDR_STATUS = 8'h18;
  localparam logic [7:0] ADDR_RESULT = 8'h1c;
  localparam logic [7:0] ADDR_LADDR  = 8'h20;
  // Control and status field positions
  localparam int CTRL_ALIGN = 0;
  localparam int STAT_BUSY  = 0;
  localparam int STAT_DONE  = 1;
  localparam int STAT_ALIGN = 2;
  localparam int STAT_ABORT = 3;
  // Flag positions inside the four-bit flag field
  localparam int FLAG_V = 0;
  localparam int FLAG_C = 1;
  localparam int FLAG_Z = 2;
  localparam int FLAG_N = 3;
  // Reset values
  localparam logic [31:0] RST_WORD  = 32'h0;
  localparam logic [7:0]  RST_IMM   = 8'h0;
  localparam logic [3:0]  RST_FLAGS = 4'h0;
  // Number of legal operation codes
  localparam logic [2:0]  OP_COUNT  = 3'h6;
  // Operation codes written to the command register
  typedef enum logic [2:0] {
    OP_ST_BYTE_IMM,
    OP_ST_BYTE_REG,
    OP_ST_HALF_IMM,
    OP_ST_HALF_REG,
    OP_SUB_IMM3,
    OP_SUB_IMM8
  } cssx_op_type;
  // Execution states
  typedef enum logic {
    EX_IDLE,
    EX_MEM
  } cssx_state_type;
endpackage : cssx_pkg

// ### verification/cssx_mem_model.sv
// Data memory responder for store requests: prompt, slow or aborting
module cssx_mem_model (
  input  wire logic       clk_i,
  input  wire logic       rst_b_i,
  input  wire logic       req_i,
  input  wire logic [3:0] dly_i,
  input  wire logic       abort_en_i,
  output logic            done_o,
  output logic            abort_o
);
  timeunit 1ns;
  timeprecision 100ps;

  logic [3:0] cnt;

  // One pulse per request after dly_i idle cycles; never pulses twice for one request
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cnt     <= 4'h0;
      done_o  <= 1'b0;
      abort_o <= 1'b0;
    end else begin
      done_o  <= 1'b0;
      abort_o <= 1'b0;
      if (req_i && !done_o && !abort_o) begin
        if (cnt == dly_i) begin
          done_o  <= !abort_en_i;
          abort_o <= abort_en_i;
          cnt     <= 4'h0;
        end else begin
          cnt <= cnt + 4'h1;
        end
      end else begin
        cnt <= 4'h0;
      end
    end
  end
endmodule : cssx_mem_model

// ### verification/cssx_exec_tb.sv
// Self-checking bench for the compact store and subtract unit
module cssx_exec_tb import cssx_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;

  typedef struct packed {
    cssx_op_type op;
    logic [31:0] base, off, src;
    logic [7:0]  imm;
    logic [31:0] ea, ed;
    logic [3:0]  eb, ef;
  } cssx_row_type;

  cssx_row_type rows [10];
  logic        clk, rst_b, hsel, hwrite, hready, hresp, req, abort_en, req_q;
  logic        mdone, mabort, exc_align, exc_abort;
  logic [1:0]  htrans;
  logic [3:0]  mbe, dly;
  logic [31:0] haddr, hwdata, hrdata, maddr, mwdata, rd;
  int          n_req, n_align, n_abort, n_mismatch, cmp_count, a0, r0;

  cssx_exec dut_u (
    .CORE_CLK_I(clk), .RST_B_I(rst_b), .HSEL_I(hsel), .HADDR_I(haddr),
    .HTRANS_I(htrans), .HWRITE_I(hwrite), .HSIZE_I(3'h2), .HWDATA_I(hwdata),
    .HREADY_I(hready), .HRDATA_O(hrdata), .HREADYOUT_O(hready), .HRESP_O(hresp),
    .DMEM_REQ_O(req), .DMEM_ADDR_O(maddr), .DMEM_WDATA_O(mwdata), .DMEM_BE_O(mbe),
    .DMEM_DONE_I(mdone), .DMEM_ABORT_I(mabort), .EXC_ALIGN_O(exc_align),
    .EXC_ABORT_O(exc_abort));

  cssx_mem_model mem_u (
    .clk_i(clk), .rst_b_i(rst_b), .req_i(req), .dly_i(dly),
    .abort_en_i(abort_en), .done_o(mdone), .abort_o(mabort));

  // Clock generator, 25 ns period
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // Counts request starts and exception pulses
  always @(posedge clk) begin
    req_q <= req;
    if (req && !req_q) n_req <= n_req + 1;
    if (exc_align) n_align <= n_align + 1;
    if (exc_abort) n_abort <= n_abort + 1;
  end

  task automatic results();
    if (n_mismatch == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : results

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  // Single word transfer: hold address phase, then data phase, each until hready
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd);
    hsel   <= 1'b1;
    haddr  <= {24'h0, a};
    htrans <= 2'b10;
    hwrite <= w;
    do @(posedge clk); while (hready !== 1'b1);
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge clk); while (hready !== 1'b1);
    rd = hrdata;
  endtask : xfer

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask : wr

  task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    chk(nm, e, rd);
  endtask : rdchk

  // Waits a bounded time for the store request to reach a level
  task automatic wait_req(input logic lvl);
    int i;
    i = 0;
    while (req !== lvl && i < 40) begin
      @(posedge clk);
      i++;
    end
    chk("request level", 32'(lvl), 32'(req));
  endtask : wait_req

  // Watchdog
  initial begin
    #(25 * 5000);
    n_mismatch++;
    results();
  end

  // Main sequence: reset, table of operations, then awkward cases
  initial begin
    rows = '{
      '{OP_ST_BYTE_IMM, 32'h1000_0003, 32'h0, 32'ha5a5_a5c3, 8'hff, 32'h1000_0022, 32'hc3c3_c3c3, 4'h4, 4'h0},
      '{OP_ST_BYTE_IMM, 32'h100, 32'hffff_ffff, 32'h1234_5678, 8'he0, 32'h100, 32'h7878_7878, 4'h1, 4'h0},
      '{OP_ST_BYTE_REG, 32'h2000_0000, 32'h7, 32'h11, 8'h1f, 32'h2000_0007, 32'h1111_1111, 4'h8, 4'h0},
      '{OP_ST_HALF_IMM, 32'h3000_0000, 32'h0, 32'hdead_beef, 8'h1f, 32'h3000_003e, 32'hbeef_beef, 4'hc, 4'h0},
      '{OP_ST_HALF_REG, 32'hffff_fffe, 32'h4, 32'h1234, 8'h0, 32'h2, 32'h1234_1234, 4'hc, 4'h0},
      '{OP_SUB_IMM3, 32'h5, 32'h0, 32'h9999_9999, 8'hff, 32'hffff_fffe, 32'h0, 4'h0, 4'h8},
      '{OP_SUB_IMM3, 32'h8000_0000, 32'h0, 32'h9999_9999, 8'h01, 32'h7fff_ffff, 32'h0, 4'h0, 4'h3},
      '{OP_SUB_IMM3, 32'h3, 32'h0, 32'h9999_9999, 8'h03, 32'h0, 32'h0, 4'h0, 4'h6},
      '{OP_SUB_IMM8, 32'h7777_7777, 32'h0, 32'h0, 8'h80, 32'hffff_ff80, 32'h0, 4'h0, 4'h8},
      '{OP_SUB_IMM8, 32'h7777_7777, 32'h0, 32'h8000_0010, 8'h20, 32'h7fff_fff0, 32'h0, 4'h0, 4'h3}};
    hsel = 1'b0;
    htrans = 2'b00;
    haddr = 32'h0;
    hwrite = 1'b0;
    hwdata = 32'h0;
    dly = 4'h0;
    abort_en = 1'b0;
    rst_b = 1'b0;
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    repeat (4) @(posedge clk);
    rdchk("status reset", ADDR_STATUS, 32'h0);
    wr(8'h40, 32'hffff_ffff);
    rdchk("unmapped", 8'h40, 32'h0);
    foreach (rows[i]) begin
      dly <= 4'(3 * (i % 3));
      wr(ADDR_BASE, rows[i].base);
      wr(ADDR_OFFSET, rows[i].off);
      wr(ADDR_SRC, rows[i].src);
      wr(ADDR_IMM, {24'h0, rows[i].imm});
      r0 = n_req;
      wr(ADDR_CMD, 32'(rows[i].op));
      if (rows[i].op inside {OP_SUB_IMM3, OP_SUB_IMM8}) begin
        rdchk("result", ADDR_RESULT, rows[i].ea);
        xfer(1'b0, ADDR_STATUS, 32'h0);
        chk("flags", 32'(rows[i].ef), 32'(rd[7:4]));
        if (rows[i].op == OP_SUB_IMM8) rdchk("dest", ADDR_SRC, rows[i].ea);
        chk("no store", 32'(r0), 32'(n_req));
      end else begin
        wait_req(1'b1);
        chk("address", rows[i].ea, maddr);
        chk("data", rows[i].ed, mwdata);
        chk("lanes", 32'(rows[i].eb), 32'(mbe));
        wait_req(1'b0);
        rdchk("done", ADDR_STATUS, 32'h2);
      end
      wr(ADDR_STATUS, 32'he);
    end
    chk("response", 32'h0, 32'(hresp));
    // Misaligned halfword with the check off still completes
    wr(ADDR_BASE, 32'h1001);
    wr(ADDR_OFFSET, 32'h0);
    a0 = n_align;
    wr(ADDR_CMD, 32'(OP_ST_HALF_REG));
    wait_req(1'b1);
    chk("odd lanes", 32'h3, 32'(mbe));
    wait_req(1'b0);
    // Check on: halfword faults without a request, byte store still goes out
    wr(ADDR_CTRL, 32'h1);
    r0 = n_req;
    wr(ADDR_CMD, 32'(OP_ST_HALF_REG));
    rdchk("fault address", ADDR_LADDR, 32'h1001);
    xfer(1'b0, ADDR_STATUS, 32'h0);
    chk("align bit", 32'h1, 32'(rd[2]));
    chk("align pulse", 32'(a0 + 1), 32'(n_align));
    chk("fault no store", 32'(r0), 32'(n_req));
    wr(ADDR_CMD, 32'(OP_ST_BYTE_REG));
    wait_req(1'b1);
    wait_req(1'b0);
    // A slow abort suppresses completion; a command while busy is ignored
    wr(ADDR_STATUS, 32'he);
    abort_en <= 1'b1;
    dly <= 4'h9;
    r0 = n_req;
    wr(ADDR_CMD, 32'(OP_ST_BYTE_IMM));
    wait_req(1'b1);
    xfer(1'b0, ADDR_STATUS, 32'h0);
    chk("busy", 32'h1, 32'(rd[0]));
    wr(ADDR_CMD, 32'(OP_ST_BYTE_REG));
    wait_req(1'b0);
    abort_en <= 1'b0;
    xfer(1'b0, ADDR_STATUS, 32'h0);
    chk("abort state", 32'h4, 32'(rd[3:1]));
    chk("abort pulse", 32'h1, 32'(n_abort));
    chk("busy refused", 32'(r0 + 1), 32'(n_req));
    // Codes above the last operation are ignored; flags keep the last subtract
    wr(ADDR_STATUS, 32'he);
    r0 = n_req;
    wr(ADDR_CMD, 32'h7);
    rdchk("illegal op", ADDR_STATUS, 32'h30);
    chk("illegal no store", 32'(r0), 32'(n_req));
    // Reset in mid-store drops the request and clears the registers
    wr(ADDR_CMD, 32'(OP_ST_BYTE_IMM));
    wait_req(1'b1);
    rst_b <= 1'b0;
    repeat (2) @(posedge clk);
    chk("reset request", 32'h0, 32'(req));
    chk("reset ready", 32'h1, 32'(hready));
    rst_b <= 1'b1;
    repeat (4) @(posedge clk);
    rdchk("reset ctrl", ADDR_CTRL, 32'h0);
    rdchk("reset status", ADDR_STATUS, 32'h0);
    results();
  end
endmodule : cssx_exec_tb
